//--- rtl/tcc_pkg.sv
// Constants, field layout and register map of the timer capture/compare channels.
// Contract
// - Three external channels, halves A and B.
// - Internal fourth channel compares only, never captures.
// - Select bit 1 puts a half in capture.
// - Select bit 0 compares counter with value.
// - Software capture bit copies counter, self-clears.
// - Edge field: off, rising, falling, both.
// - Capture sets event flag, irq when enabled.
// - Capture on set flag sets overcapture flag.
// - Writing 0 to clear register clears flags.
// - Edge captures work while counter is stopped.
// - Channels 2 and 3 capture their own pins.
// - Channel 1A source: pin or three-pin XOR.
// - Channel 1B source: pin or internal trigger.
// - Trigger select field chooses internal trigger source.
// - Output mode field: force, match actions, PWM.
// - Polarity bit inverts the compare output.
// - Compare match sets flag, irq when enabled.
// - Match requests ADC when both enables set.
// - Unbuffered compare writes take effect immediately.
// - Buffered compare values load on update event.
// - Forced modes still compare and set flags.
// - Update event comes at each counter overflow.
package tcc_pkg;
    localparam int CW = 16;
    localparam int NH = 6;
    localparam int NC = 7;
    localparam int CTL_W = 12;
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_CTRL3 = 8'h08;
    localparam logic [7:0] OFF_CCR1A = 8'h10;
    localparam logic [7:0] OFF_CCR4 = 8'h28;
    localparam logic [7:0] OFF_FLT = 8'h2c;
    localparam logic [7:0] OFF_MS = 8'h30;
    localparam logic [7:0] OFF_TRG = 8'h34;
    localparam logic [7:0] OFF_ISR = 8'h38;
    localparam logic [7:0] OFF_ICR = 8'h3c;
    localparam int CTL_CS = 0;
    localparam int CTL_EDGE = 2;
    localparam int CTL_SWCAP = 6;
    localparam int CTL_BUF = 8;
    localparam int CTL_IE = 10;
    localparam int FLT_W = 4;
    localparam int FLT_POL = 3;
    localparam int MS_SRC1A = 0;
    localparam int MS_SRC1B = 1;
    localparam int MS_TS = 2;
    localparam int MS_BUF4 = 5;
    localparam int MS_IE4 = 6;
    localparam int TRG_ADC = 0;
    localparam int TRG_MEN = 1;
    localparam int ISR_OVC = 8;
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [2:0] OM_LOW = 3'h0;
    localparam logic [2:0] OM_HIGH = 3'h1;
    localparam logic [2:0] OM_CLR = 3'h2;
    localparam logic [2:0] OM_SET = 3'h3;
    localparam logic [2:0] OM_TOG = 3'h4;
    localparam logic [2:0] OM_PULSE = 3'h5;
    localparam logic [2:0] OM_PWM1 = 3'h6;
    localparam logic [2:0] OM_PWM2 = 3'h7;
    localparam logic [2:0] TS_ETR = 3'h0;
    localparam logic [2:0] TS_ITR = 3'h1;
    localparam logic [2:0] TS_EDGE1A = 3'h5;
    localparam logic [2:0] TS_FILT1A = 3'h6;
    localparam logic [2:0] TS_FILT1B = 3'h7;
    localparam logic [CTL_W-1:0] CTL_RST = 12'h000;
    localparam logic [CW-1:0] CCR_RST = 16'h0000;
    localparam logic [27:0] FLT_RST = 28'h0000000;
    localparam logic [6:0] MS_RST = 7'h00;
    localparam logic [7:0] TRG_RST = 8'h00;
endpackage

//--- rtl/tcc_channels.sv
// Compare/capture channel section of the advanced timer with an APB register port.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module tcc_channels
    import tcc_pkg::*;
(
    input wire logic sys_clk, // Peripheral clock, 100 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic [tcc_pkg::CW-1:0] main_counter, // Main counter value.
    input wire logic count_down, // Counter direction, high when counting down.
    input wire logic update_event, // Update event pulse, one per overflow.
    input wire logic [tcc_pkg::NH-1:0] cap_pin, // Capture pins 1A,1B,2A,2B,3A,3B.
    input wire logic filtered_external_trigger, // External trigger, asynchronous.
    input wire logic interconnect_trigger, // Interconnect trigger, same clock.
    output logic [tcc_pkg::NH-1:0] cmp_out, // Compare outputs after polarity.
    output logic internal_cmp_out, // Internal channel compare output.
    output logic irq_req, // Interrupt request level.
    output logic adc_req // ADC conversion request pulse.
);
    import tcc_pkg::*;

    // Returns the next compare output level for one half.
    function automatic logic out_next(input logic [2:0] mode, input logic cur,
        input logic mev, input logic mlv, input logic dn,
        input logic [CW-1:0] cnt, input logic [CW-1:0] ccr);
        logic pwm1;
        pwm1 = dn ? (cnt <= ccr) : (cnt < ccr);
        case (mode)
            OM_LOW: out_next = 1'b0;
            OM_HIGH: out_next = 1'b1;
            OM_CLR: out_next = mev ? 1'b0 : cur;
            OM_SET: out_next = mev ? 1'b1 : cur;
            OM_TOG: out_next = mev ? ~cur : cur;
            OM_PULSE: out_next = mlv;
            OM_PWM1: out_next = pwm1;
            default: out_next = ~pwm1;
        endcase
    endfunction

    // Decides whether a filtered level change is a valid capture edge.
    function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic prev);
        case (sel)
            EDGE_RISE: edge_hit = now & ~prev;
            EDGE_FALL: edge_hit = ~now & prev;
            EDGE_BOTH: edge_hit = now ^ prev;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    // Software-visible registers.
    logic [CTL_W-1:0] ctrl_ff [3]; // Channel control words.
    logic [CW-1:0] ccr_ff [NC]; // Compare/capture values as written or captured.
    logic [CW-1:0] act_ff [NC]; // Active compare values loaded on update.
    logic [27:0] flt_ff; // Output mode/filter and polarity fields.
    logic [6:0] ms_ff; // Source selects, trigger select, internal channel bits.
    logic [7:0] trg_ff; // ADC trigger enables.
    logic [NC-1:0] flag_ff; // Event flags.
    logic [NH-1:0] ovc_ff; // Overcapture flags.
    // Input path state.
    logic [NH:0] sync1_ff; // First synchroniser stage.
    logic [NH:0] sync2_ff; // Second synchroniser stage.
    logic pin1a_d_ff; // Delayed channel 1A level for the edge trigger.
    logic [NH-1:0] filt_ff; // Filtered levels.
    logic [NH-1:0] filt_d_ff; // Filtered levels one cycle back.
    logic [2:0] fcnt_ff [NH]; // Filter stability counters.
    // Compare path state.
    logic [NC-1:0] mlv_ff; // Match level one cycle back.
    logic [NC-1:0] ost_ff; // Compare output states before polarity.
    logic [NH-1:0] cmp_out_ff; // Registered pin outputs.
    logic int_out_ff; // Registered internal output.
    logic irq_ff; // Registered interrupt request.
    logic adc_ff; // Registered ADC request.
    // Bus state.
    logic pready_ff; // Set for the second access cycle.
    logic [31:0] prdata_ff; // Captured read word.

    // Bus decode.
    wire acc_first = psel & penable & ~pready_ff;
    wire acc_done = psel & penable & pready_ff;
    wire wr_en = acc_done & pwrite;
    wire [7:0] ccr_off = paddr - OFF_CCR1A;
    wire ccr_hit = (paddr >= OFF_CCR1A) && (paddr <= OFF_CCR4) && (paddr[1:0] == 2'h0);
    wire [2:0] ccr_sel = ccr_off[4:2];
    wire ctl_hit = (paddr == OFF_CTRL1) | (paddr == OFF_CTRL2) | (paddr == OFF_CTRL3);
    wire [1:0] ctl_sel = paddr[3:2];
    wire reg_hit = ctl_hit | ccr_hit | (paddr == OFF_FLT) | (paddr == OFF_MS)
        | (paddr == OFF_TRG) | (paddr == OFF_ISR) | (paddr == OFF_ICR);
    wire [NC-1:0] clr_flag = (wr_en && paddr == OFF_ICR) ? ~pwdata[NC-1:0] : '0;
    wire [NH-1:0] clr_ovc = (wr_en && paddr == OFF_ICR) ? ~pwdata[ISR_OVC+NH-1:ISR_OVC] : '0;
    wire [31:0] rd_word = ctl_hit ? {20'h0, ctrl_ff[ctl_sel] & ~12'h0c0}
        : ccr_hit ? {16'h0, ccr_ff[ccr_sel]}
        : (paddr == OFF_FLT) ? {4'h0, flt_ff}
        : (paddr == OFF_MS) ? {25'h0, ms_ff}
        : (paddr == OFF_TRG) ? {24'h0, trg_ff}
        : (paddr == OFF_ISR) ? {18'h0, ovc_ff, 1'b0, flag_ff}
        : 32'h0;

    // Internal trigger and capture sources.
    wire edge1a = sync2_ff[0] ^ pin1a_d_ff;
    wire [2:0] ts_sel = ms_ff[MS_TS+2:MS_TS];
    wire ts_sig = (ts_sel == TS_ETR) ? sync2_ff[NH]
        : (ts_sel == TS_ITR) ? interconnect_trigger
        : (ts_sel == TS_EDGE1A) ? edge1a
        : (ts_sel == TS_FILT1A) ? filt_ff[0]
        : (ts_sel == TS_FILT1B) ? filt_ff[1] : 1'b0;
    wire hall = sync2_ff[0] ^ sync2_ff[2] ^ sync2_ff[4];
    logic [NH-1:0] fin; // Filter inputs per half.
    assign fin[0] = ms_ff[MS_SRC1A] ? hall : sync2_ff[0];
    assign fin[1] = ms_ff[MS_SRC1B] ? ts_sig : sync2_ff[1];
    assign fin[NH-1:2] = sync2_ff[NH-1:2];

    // Per-half decode of control fields, captures, matches and output levels.
    logic [NH-1:0] is_cap; // Half in capture mode.
    logic [NH-1:0] cap_ev; // Capture this cycle.
    logic [NC-1:0] buf_en; // Compare buffering enabled.
    logic [NC-1:0] ie; // Interrupt enables.
    logic [NC-1:0] m_lvl; // Counter equals active value while comparing.
    logic [NC-1:0] m_ev; // First cycle of a match.
    logic [NC-1:0] ost_nxt; // Next output states.
    logic [NC-1:0] m_en; // Match ADC trigger enables.
    logic [CW-1:0] act_eff [NC]; // Value the comparator uses.
    logic [2:0] mode [NC]; // Output mode or filter length.
    genvar g;
    generate
        for (g = 0; g < NC; g++) begin : g_ch
            if (g < NH) begin : g_ext
                wire [CTL_W-1:0] c = ctrl_ff[g/2];
                wire s = 1'(g % 2); // Half select: 0 for A, 1 for B.
                assign is_cap[g] = c[CTL_CS+s];
                assign buf_en[g] = c[CTL_BUF+s];
                assign ie[g] = c[CTL_IE+s];
                wire sw = wr_en && ctl_hit && (ctl_sel == 2'(g/2)) && pwdata[CTL_SWCAP+s];
                wire hw = edge_hit(c[CTL_EDGE+2*s+:2], filt_ff[g], filt_d_ff[g]);
                assign cap_ev[g] = is_cap[g] & (sw | hw);
            end else begin : g_int
                assign buf_en[g] = ms_ff[MS_BUF4];
                assign ie[g] = ms_ff[MS_IE4];
            end
            assign mode[g] = flt_ff[g*FLT_W+:3];
            assign act_eff[g] = buf_en[g] ? act_ff[g] : ccr_ff[g];
            assign m_lvl[g] = ((g == NH) || !is_cap[g % NH]) && (main_counter == act_eff[g]);
            assign m_ev[g] = m_lvl[g] & ~mlv_ff[g];
            assign ost_nxt[g] = out_next(mode[g], ost_ff[g], m_ev[g], m_lvl[g], count_down,
                main_counter, act_eff[g]);
            assign m_en[g] = trg_ff[TRG_MEN+g];
        end
    endgenerate
    wire [NC-1:0] flag_set = {1'b0, cap_ev} | m_ev;

    // Bus handshake: one wait state, read word latched in the first access cycle.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= acc_first;
            if (acc_first) begin
                prdata_ff <= rd_word;
            end
        end
    end

    // Control registers; the software capture bits never store and read as zero.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < 3; i++) begin
                ctrl_ff[i] <= CTL_RST;
            end
            flt_ff <= FLT_RST;
            ms_ff <= MS_RST;
            trg_ff <= TRG_RST;
        end else if (wr_en) begin
            if (ctl_hit && ctl_sel != 2'h3) begin
                ctrl_ff[ctl_sel] <= pwdata[CTL_W-1:0] & ~12'h0c0;
            end
            if (paddr == OFF_FLT) begin
                flt_ff <= pwdata[27:0];
            end
            if (paddr == OFF_MS) begin
                ms_ff <= pwdata[6:0];
            end
            if (paddr == OFF_TRG) begin
                trg_ff <= pwdata[7:0];
            end
        end
    end

    // Compare values: a capture takes the counter and wins over a bus write in the
    // same cycle, since the captured time stamp cannot be repeated later.
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < NC; i++) begin
            if (rst) begin
                ccr_ff[i] <= CCR_RST;
                act_ff[i] <= CCR_RST;
            end else begin
                if (i < NH && cap_ev[i % NH]) begin
                    ccr_ff[i] <= main_counter;
                end else if (wr_en && ccr_hit && ccr_sel == 3'(i)) begin
                    ccr_ff[i] <= pwdata[CW-1:0];
                end
                if (update_event) begin
                    act_ff[i] <= ccr_ff[i];
                end
            end
        end
    end

    // Flags: a set in the same cycle as a clear wins.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flag_ff <= '0;
            ovc_ff <= '0;
        end else begin
            flag_ff <= (flag_ff & ~clr_flag) | flag_set;
            ovc_ff <= (ovc_ff & ~clr_ovc) | (cap_ev & flag_ff[NH-1:0]);
        end
    end

    // Two-stage synchroniser; nothing but the second stage reads the first.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            pin1a_d_ff <= 1'b0;
        end else begin
            sync1_ff <= {filtered_external_trigger, cap_pin};
            sync2_ff <= sync1_ff;
            pin1a_d_ff <= sync2_ff[0];
        end
    end

    // Digital filter: a new level is accepted after it has held for the programmed
    // number of cycles; zero passes it on the next edge. Runs whether or not the
    // counter does, so edges are caught while the timer is stopped.
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < NH; i++) begin
            if (rst) begin
                filt_ff[i] <= 1'b0;
                filt_d_ff[i] <= 1'b0;
                fcnt_ff[i] <= 3'h0;
            end else begin
                filt_d_ff[i] <= filt_ff[i];
                if (fin[i] == filt_ff[i]) begin
                    fcnt_ff[i] <= 3'h0;
                end else if (fcnt_ff[i] >= mode[i]) begin
                    filt_ff[i] <= fin[i];
                    fcnt_ff[i] <= 3'h0;
                end else begin
                    fcnt_ff[i] <= fcnt_ff[i] + 3'h1;
                end
            end
        end
    end

    // Output stage, interrupt and ADC requests.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mlv_ff <= '0;
            ost_ff <= '0;
            cmp_out_ff <= '0;
            int_out_ff <= 1'b0;
            irq_ff <= 1'b0;
            adc_ff <= 1'b0;
        end else begin
            mlv_ff <= m_lvl;
            ost_ff <= ost_nxt;
            for (int i = 0; i < NH; i++) begin
                cmp_out_ff[i] <= ost_nxt[i] ^ flt_ff[i*FLT_W+FLT_POL];
            end
            int_out_ff <= ost_nxt[NH] ^ flt_ff[NH*FLT_W+FLT_POL];
            irq_ff <= |(flag_ff & ie);
            adc_ff <= trg_ff[TRG_ADC] & |(m_ev & m_en);
        end
    end

    assign pready = pready_ff;
    assign pslverr = acc_done & ~reg_hit;
    assign prdata = prdata_ff;
    assign cmp_out = cmp_out_ff;
    assign internal_cmp_out = int_out_ff;
    assign irq_req = irq_ff;
    assign adc_req = adc_ff;
endmodule // tcc_channels

//--- tb/tcc_monitor.sv
// Port-level assertions for the timer capture/compare channels.
`timescale 1ns/1ps
module tcc_monitor
    import tcc_pkg::*;
(
    input wire logic sys_clk, // Clock.
    input wire logic rst, // Reset, active high.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [7:0] paddr, // APB address.
    input wire logic [31:0] prdata, // APB read data.
    input wire logic pready, // APB ready.
    input wire logic pslverr, // APB error.
    input wire logic irq_req, // Interrupt request.
    input wire logic adc_req, // ADC request.
    input wire logic [tcc_pkg::NH-1:0] cmp_out // Compare outputs.
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Decoded map; 0x0c is the one hole below the flag clear word.
    wire mapped = (paddr inside {OFF_CTRL1, OFF_CTRL2, OFF_CTRL3, OFF_FLT, OFF_MS, OFF_TRG, OFF_ISR, OFF_ICR})
        || (paddr >= OFF_CCR1A && paddr <= OFF_CCR4 && paddr[1:0] == 2'h0);
    pready_wait_a:
        assert property (psel && !penable |=> !pready ##1 pready) else $error("Ready not after one wait state.");
    ready_pulse_a:
        assert property (pready |=> !pready) else $error("Ready held longer than one cycle.");
    ready_access_a:
        assert property (pready |-> psel && penable && $past(psel && penable)) else $error("Ready outside access.");
    err_decode_a:
        assert property (pready |-> pslverr == !mapped) else $error("Error flag disagrees with the map.");
    err_ready_a:
        assert property (pslverr |-> pready) else $error("Error without ready.");
    err_read_a:
        assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("Refused read gave data.");
    irq_clear_a:
        assert property ($fell(irq_req) |-> $past(pready && pwrite, 2) || $past(rst)) else $error("Irq fell alone.");
    reset_quiet_a:
        assert property (@(posedge sys_clk) disable iff (1'b0) rst |=> !pready && !irq_req && !adc_req
            && cmp_out == '0) else $error("Outputs not cleared by reset.");
    // Main scenarios that the bench is expected to reach.
    wr_seen_c: cover property (pready && pwrite && !pslverr);
    err_seen_c: cover property (pready && pslverr);
    adc_seen_c: cover property (adc_req);
    irq_drop_c: cover property ($fell(irq_req));
endmodule // tcc_monitor
bind tcc_channels tcc_monitor u_tcc_monitor (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
    .adc_req(adc_req), .cmp_out(cmp_out));

//--- tb/tcc_pin_model.sv
// Pin-side model driving the capture pins and the external trigger line.
`timescale 1ns/1ps
module tcc_pin_model
    import tcc_pkg::*;
(
    input wire logic sys_clk, // Clock.
    input wire logic rst, // Reset, active high.
    input wire logic [tcc_pkg::NH-1:0] pin_req, // Requested pin levels.
    input wire logic etr_req, // Requested trigger level.
    output logic [tcc_pkg::NH-1:0] cap_pin, // Capture pins.
    output logic filtered_external_trigger // External trigger line.
);
    // Pins follow the request one cycle late; they are always driven, so no floating level arises.
    always_ff @(posedge sys_clk) begin
        cap_pin <= rst ? '0 : pin_req;
        filtered_external_trigger <= rst ? 1'b0 : etr_req;
    end
endmodule // tcc_pin_model

//--- tb/tcc_channels_test.sv
// Self-checking bench for the timer capture/compare channels.
`timescale 1ns/1ps
module tcc_channels_test;
    import tcc_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, count_down = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, update_event = 1'b0, interconnect_trigger = 1'b0, etr_req = 1'b0, etr;
    logic [CW-1:0] main_counter = 16'hffff; // Away from the reset compare values.
    logic [NH-1:0] pin_req = '0, cap_pin, cmp_out;
    logic internal_cmp_out, irq_req, adc_req;
    int bad_count = 0, comparisons = 0, cycles = 0, adc_cnt = 0;
    tcc_channels u_tcc_channels (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .main_counter(main_counter), .count_down(count_down), .update_event(update_event), .cap_pin(cap_pin),
        .filtered_external_trigger(etr), .interconnect_trigger(interconnect_trigger), .cmp_out(cmp_out),
        .internal_cmp_out(internal_cmp_out), .irq_req(irq_req), .adc_req(adc_req));
    tcc_pin_model u_tcc_pin_model (.sys_clk(sys_clk), .rst(rst), .pin_req(pin_req), .etr_req(etr_req),
        .cap_pin(cap_pin), .filtered_external_trigger(etr));
    // Free-running clock, 10 ns period.
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // ADC pulses last one cycle, so sampling mid-cycle counts each exactly once.
    always @(negedge sys_clk) begin
        if (adc_req === 1'b1) adc_cnt++;
    end
    // Hang guard, well above the expected run length.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (bad_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer. Ready, data and error are read just after each rising edge, before the design's
    // registers move, so they are the values that edge sampled; only the hang guard ends a long wait.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x);
    endtask
    // Counter leaves the value and comes back, giving one fresh match.
    task automatic hit(input logic [15:0] v);
        main_counter <= v + 16'h1;
        repeat (2) @(posedge sys_clk);
        main_counter <= v;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic out_is(input logic x);
        repeat (3) @(negedge sys_clk);
        chk(32'(cmp_out[4]), 32'(x));
        @(posedge sys_clk);
    endtask
    task automatic s_regs();
        logic [31:0] q;
        logic e;
        rd(OFF_CTRL1, 32'(CTL_RST));
        rd(OFF_FLT, 32'(FLT_RST));
        rd(OFF_ISR, 32'h0);
        apb(1'b1, 8'h0c, 32'hffff, q, e);
        chk(32'(e), 32'h1);
        apb(1'b0, 8'h0c, 32'h0, q, e);
        chk(q, 32'h0);
    endtask
    task automatic s_swcap();
        main_counter <= 16'h1234;
        wr(OFF_CTRL1, 32'h401);
        wr(OFF_CTRL1, 32'h441);
        rd(OFF_CCR1A, 32'h1234);
        rd(OFF_CTRL1, 32'h401);
        chk(32'(irq_req), 32'h1);
        main_counter <= 16'h2345;
        wr(OFF_CTRL1, 32'h441);
        rd(OFF_ISR, 32'h101);
        wr(OFF_ICR, 32'hfffffefe);
        rd(OFF_ISR, 32'h0);
        chk(32'(irq_req), 32'h0);
    endtask
    // Every edge code on pin 2A with a stopped counter; each selected edge must give one capture only.
    task automatic s_edges();
        for (int e = 0; e < 4; e++) begin
            wr(OFF_CTRL2, 32'h1 | (e << 2));
            main_counter <= 16'(32'h100 + e);
            pin_req[2] <= 1'b1;
            repeat (8) @(posedge sys_clk);
            rd(OFF_ISR, (e % 2 == 1) ? 32'h4 : 32'h0);
            wr(OFF_ICR, 32'h0);
            main_counter <= 16'(32'h200 + e);
            pin_req[2] <= 1'b0;
            repeat (8) @(posedge sys_clk);
            rd(OFF_ISR, (e >= 2) ? 32'h4 : 32'h0);
            rd(8'h18, (e >= 2) ? 32'h200 + e : ((e == 1) ? 32'h101 : 32'h0));
            wr(OFF_ICR, 32'h0);
        end
    endtask
    task automatic s_src();
        main_counter <= 16'hffff;
        wr(OFF_CTRL2, 32'h0);
        wr(OFF_MS, 32'h7);
        wr(OFF_CTRL1, 32'h17);
        pin_req[4] <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rd(OFF_ISR, 32'h1);
        interconnect_trigger <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rd(OFF_ISR, 32'h3);
        wr(OFF_ICR, 32'h0);
        wr(OFF_MS, 32'h3);
        etr_req <= 1'b1;
        repeat (12) @(posedge sys_clk);
        rd(OFF_ISR, 32'h2);
        // Filtered 1A as trigger: one 1A rise captures on both halves of channel 1.
        wr(OFF_ICR, 32'h0);
        wr(OFF_MS, 32'h1a);
        pin_req[0] <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rd(OFF_ISR, 32'h3);
        // Edge of 1A as trigger: a 1A fall gives a one-cycle pulse that 1B takes as a rise.
        wr(OFF_ICR, 32'h0);
        wr(OFF_MS, 32'h16);
        pin_req[0] <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rd(OFF_ISR, 32'h2);
    endtask
    task automatic s_compare();
        logic [2:0] md [5] = '{OM_LOW, OM_HIGH, OM_SET, OM_CLR, OM_TOG};
        logic ex [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
        main_counter <= 16'h10;
        wr(OFF_CTRL1, 32'h0);
        wr(OFF_MS, 32'h0);
        wr(OFF_CTRL3, 32'h400);
        wr(OFF_TRG, 32'h21);
        wr(8'h20, 32'h50);
        wr(OFF_ICR, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(OFF_FLT, 32'(md[i]) << 16);
            hit(16'h50);
            out_is(ex[i]);
            rd(OFF_ISR, 32'h10);
            chk(32'(irq_req), 32'h1);
            wr(OFF_ICR, 32'h0);
        end
        wr(OFF_FLT, 32'(OM_PULSE) << 16);
        hit(16'h50);
        out_is(1'b1);
        main_counter <= 16'h10;
        out_is(1'b0);
        chk(32'(adc_cnt), 32'h6);
        wr(OFF_FLT, 32'(OM_PWM1) << 16);
        out_is(1'b1);
        // Counting down, the equal value still counts as inside the high part.
        main_counter <= 16'h50;
        count_down <= 1'b1;
        out_is(1'b1);
        count_down <= 1'b0;
        main_counter <= 16'h10;
        wr(OFF_FLT, 32'(OM_PWM2) << 16);
        out_is(1'b0);
        wr(OFF_FLT, 32'h9 << 16);
        out_is(1'b0);
    endtask
    task automatic s_buffer();
        wr(OFF_CTRL3, 32'h500);
        wr(OFF_ICR, 32'h0);
        wr(8'h20, 32'h60);
        hit(16'h60);
        rd(OFF_ISR, 32'h0);
        update_event <= 1'b1;
        @(posedge sys_clk);
        update_event <= 1'b0;
        hit(16'h60);
        rd(OFF_ISR, 32'h10);
        wr(OFF_ICR, 32'h0);
        wr(OFF_CCR4, 32'h33);
        wr(OFF_FLT, 32'(OM_SET) << 24);
        hit(16'h33);
        chk(32'(internal_cmp_out), 32'h1);
        rd(OFF_ISR, 32'h40);
    endtask
    // Reset for two cycles, then the scenarios in turn.
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        s_regs();
        s_swcap();
        s_edges();
        s_src();
        s_compare();
        s_buffer();
        report_and_stop();
    end
endmodule // tcc_channels_test
